// ---- core/iop_bus_ports.sv ----
`timescale 1ns/1ps
// Function
// R1 - Strap low selects external program fetch
// R2 - One data strobe per external transfer
// R3 - Address strobe pulses every machine cycle
// R4 - Low address byte driven on port 1
// R5 - Software floats strobes, direction, ports 0/1
// R6 - Direction line low only during writes
// R7 - Reset pulses under four clocks ignored
// R8 - Reset latched fifth clock, held eighteen
// R9 - During reset data strobe low, address toggles
// R10 - Execution restarts at fixed reset vector
// R11 - Board holds reset low at power-up
// R12 - Port 0 nibbles: I/O or address
// R13 - Port 0 handshake on P32/P35
// R14 - Port 0 supplies upper address nibbles
// R15 - ROM-off reset: address nibbles, extended timing
// R16 - Port 1 input, output or bus
// R17 - Port 1 handshake on P33/P34
// R18 - High locations go external via port 1
// R19 - Bus request P34, acknowledge P33
// R20 - Port 2 bitwise direction, global open-drain
// R21 - Port 2 handshake P31/P36, P27 direction
// R22 - Interlocked data-available and ready handshake
module iop_bus_ports
    import iop_pkg::*;
#(
    parameter int HOLD_CYC = RST_HOLD_CYC
) (
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        rst,
    // Reset pin, strap and restart
    input  wire logic        ext_reset_in_n,
    input  wire logic        rom_disable_n,
    output logic             internal_reset_ff,
    output logic             rom_off_ff,
    output logic             exec_start_ff,
    output logic [15:0]      exec_addr_ff,
    // Core memory requests
    input  wire logic        mem_req,
    input  wire logic        mem_we,
    input  wire logic [15:0] mem_addr,
    input  wire logic [7:0]  mem_wdata,
    output logic [7:0]       mem_rdata_ff,
    output logic             mem_done_ff,
    output logic             mem_internal_ff,
    // Port configuration
    input  wire logic        p0_addr_lo,
    input  wire logic        p0_addr_hi,
    input  wire logic [1:0]  p0_dir,
    input  wire logic        p0_cfg_wr,
    input  wire logic        ext_timing_cfg,
    input  wire logic [1:0]  p1_mode,
    input  wire logic [7:0]  p2_dir,
    input  wire logic        p2_open_drain,
    input  wire logic [2:0]  hs_en,
    input  wire logic        bus_float_req,
    input  wire logic        bus_share_en,
    output logic             ext_timing_ff,
    output logic             bus_floated_ff,
    // Port data from the core
    input  wire logic [7:0]  p0_io_out,
    input  wire logic [7:0]  p1_io_out,
    input  wire logic [7:0]  p2_io_out,
    input  wire logic [3:0]  p3_core_out,
    input  wire logic [2:0]  hs_wr_stb,
    input  wire logic [2:0]  hs_rd_ack,
    // Port data to the core
    output logic [7:0]       p0_rd_data,
    output logic [7:0]       p1_rd_data,
    output logic [7:0]       p2_rd_data,
    output logic [2:0]       hs_full,
    output logic [2:0]       hs_busy,
    // Bus strobes
    output logic             address_strobe_n_ff,
    output logic             as_oe_ff,
    output logic             data_strobe_n_ff,
    output logic             ds_oe_ff,
    output logic             write_low_dir_ff,
    output logic             wld_oe_ff,
    // Port pins
    input  wire logic [7:0]  p0_in,
    output logic [7:0]       p0_out_ff,
    output logic [7:0]       p0_oe_ff,
    input  wire logic [7:0]  p1_in,
    output logic [7:0]       p1_out_ff,
    output logic [7:0]       p1_oe_ff,
    input  wire logic [7:0]  p2_in,
    output logic [7:0]       p2_out_ff,
    output logic [7:0]       p2_oe_ff,
    input  wire logic [3:0]  p3_in,
    output logic [3:0]       p3_out_ff
);

    iop_bus_st_t state_ff;
    iop_bus_st_t nxt_state;
    logic        xfer_ff,  nxt_xfer;
    logic        pend_ff,  nxt_pend;
    logic        we_ff,    nxt_we;
    logic [15:0] addr_ff,  nxt_addr;
    logic [7:0]  wdata_ff, nxt_wdata;
    logic        nxt_float;
    logic        override_ff;
    logic        int_rst;
    logic        p0_lo_eff, p0_hi_eff;
    logic        last_ds;
    logic        nxt_as_n, nxt_ds_n, nxt_wld;
    logic [7:0]  nxt_p0o, nxt_p0e, nxt_p1o, nxt_p1e, nxt_p2e;
    logic [3:0]  nxt_p3o;
    logic [2:0]  hs_on, hs_send, hs_in, hs_line;
    logic [7:0]  hs_pins [3];
    logic [7:0]  hs_data [3];

    iop_rst_filter #(
        .FILT_CYC       (RST_FILTER_CYC),
        .HOLD_CYC       (HOLD_CYC)
    ) u_rst (
        .clk            (clk),
        .rst            (rst),
        .ext_reset_in_n (ext_reset_in_n),
        .int_rst_ff     (int_rst)
    );

    always_ff @(posedge clk) begin
        if (rst) begin
            internal_reset_ff <= 1'b1;
            exec_start_ff     <= 1'b0;
            exec_addr_ff      <= RESET_VECTOR;
        end else begin
            internal_reset_ff <= int_rst;
            exec_start_ff     <= internal_reset_ff && !int_rst; // R10
            exec_addr_ff      <= RESET_VECTOR; // R10
        end
    end

    // Strap is caught while the reset cycle runs
    always_ff @(posedge clk) begin
        if (rst) begin
            rom_off_ff <= 1'b0;
        end else if (int_rst) begin
            rom_off_ff <= !rom_disable_n; // R1
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            override_ff   <= 1'b0;
            ext_timing_ff <= 1'b0;
        end else if (int_rst) begin
            override_ff   <= !rom_disable_n; // R15
            ext_timing_ff <= !rom_disable_n; // R15
        end else if (p0_cfg_wr) begin
            override_ff   <= 1'b0;
            ext_timing_ff <= ext_timing_cfg;
        end
    end

    assign p0_lo_eff = override_ff || p0_addr_lo; // R14
    assign p0_hi_eff = override_ff || p0_addr_hi; // R14
    assign last_ds   = (state_ff == S_DW) || (state_ff == S_DS && !ext_timing_ff);

    always_comb begin
        nxt_state = state_ff;
        nxt_xfer  = xfer_ff;
        nxt_pend  = pend_ff;
        nxt_we    = we_ff;
        nxt_addr  = addr_ff;
        nxt_wdata = wdata_ff;
        nxt_float = bus_floated_ff;
        case (state_ff)
            S_AS: begin
                nxt_state = S_AH;
            end
            S_AH: begin
                nxt_state = S_DS;
            end
            S_DS: begin
                nxt_state = ext_timing_ff ? S_DW : S_END;
            end
            S_DW: begin
                nxt_state = S_END;
            end
            S_END: begin
                nxt_state = S_AS; // R3
                nxt_xfer  = 1'b0;
                nxt_pend  = 1'b0;
                nxt_we    = 1'b0;
                nxt_float = bus_float_req &&
                            (!bus_share_en || p3_in[P3I_BUSACK]); // R19
                if (mem_req && !mem_done_ff && !nxt_float) begin
                    nxt_pend  = 1'b1;
                    nxt_addr  = mem_addr;
                    nxt_we    = mem_we;
                    nxt_wdata = mem_wdata;
                    nxt_xfer  = rom_off_ff || (mem_addr >= EXT_BASE); // R18
                end
            end
            default: begin
                nxt_state = S_AS;
            end
        endcase
        if (int_rst) begin
            nxt_state = S_AS;
            nxt_xfer  = 1'b0;
            nxt_pend  = 1'b0;
            nxt_we    = 1'b0;
            nxt_float = 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            state_ff       <= S_AS;
            xfer_ff        <= 1'b0;
            pend_ff        <= 1'b0;
            we_ff          <= 1'b0;
            addr_ff        <= 16'h0000;
            wdata_ff       <= 8'h00;
            bus_floated_ff <= 1'b0;
        end else begin
            state_ff       <= nxt_state;
            xfer_ff        <= nxt_xfer;
            pend_ff        <= nxt_pend;
            we_ff          <= nxt_we;
            addr_ff        <= nxt_addr;
            wdata_ff       <= nxt_wdata;
            bus_floated_ff <= nxt_float;
        end
    end

    // Read data taken on the edge that ends the data strobe
    always_ff @(posedge clk) begin
        if (rst) begin
            mem_done_ff     <= 1'b0;
            mem_internal_ff <= 1'b0;
            mem_rdata_ff    <= 8'h00;
        end else begin
            mem_done_ff <= pend_ff && last_ds && !int_rst;
            if (pend_ff && last_ds) begin
                mem_internal_ff <= !xfer_ff;
                mem_rdata_ff    <= (xfer_ff && !we_ff) ? p1_in : 8'h00; // R2
            end
        end
    end

    always_comb begin
        nxt_as_n = (nxt_state != S_AS); // R3
        nxt_ds_n = !(nxt_xfer && (nxt_state == S_DS || nxt_state == S_DW)); // R2
        nxt_wld  = !(nxt_xfer && nxt_we); // R6
        nxt_p1o  = p1_io_out;
        nxt_p1e  = (p1_mode == P1_MODE_OUT) ? 8'hff : 8'h00; // R16
        if (nxt_xfer) begin
            if (nxt_state == S_AS || nxt_state == S_AH) begin
                nxt_p1o = nxt_addr[7:0]; // R4
                nxt_p1e = 8'hff;
            end else begin
                nxt_p1o = nxt_wdata; // R16
                nxt_p1e = {8{nxt_we}};
            end
        end
        nxt_p0o = p0_io_out;
        nxt_p0e = {{4{p0_dir[1]}}, {4{p0_dir[0]}}}; // R12
        if (p0_lo_eff) begin
            nxt_p0o[3:0] = nxt_addr[11:8]; // R14
            nxt_p0e[3:0] = 4'hf;
        end
        if (p0_hi_eff) begin
            nxt_p0o[7:4] = nxt_addr[15:12]; // R14
            nxt_p0e[7:4] = 4'hf;
        end
        if (nxt_float) begin
            nxt_p0e = 8'h00; // R5
            nxt_p1e = 8'h00; // R5
        end
        if (int_rst) begin
            nxt_ds_n = 1'b0; // R9
            nxt_as_n = !address_strobe_n_ff; // R9
        end
        nxt_p2e = p2_dir & (p2_open_drain ? ~p2_io_out : 8'hff); // R20
        nxt_p3o = p3_core_out;
        if (bus_share_en) begin
            nxt_p3o[P3O_BUSREQ] = bus_float_req; // R19
        end else if (hs_on[1]) begin
            nxt_p3o[P3O_P1HS] = hs_line[1]; // R17
        end
        if (hs_on[0]) begin
            nxt_p3o[P3O_P0HS] = hs_line[0]; // R13
        end
        if (hs_on[2]) begin
            nxt_p3o[P3O_P2HS] = hs_line[2]; // R21
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            address_strobe_n_ff <= 1'b1;
            data_strobe_n_ff    <= 1'b1;
            write_low_dir_ff    <= 1'b1;
            as_oe_ff            <= 1'b0;
            ds_oe_ff            <= 1'b0;
            wld_oe_ff           <= 1'b0;
            p0_out_ff           <= 8'h00;
            p0_oe_ff            <= 8'h00;
            p1_out_ff           <= 8'h00;
            p1_oe_ff            <= 8'h00;
            p2_out_ff           <= 8'h00;
            p2_oe_ff            <= 8'h00;
            p3_out_ff           <= 4'hf;
        end else begin
            address_strobe_n_ff <= nxt_as_n;
            data_strobe_n_ff    <= nxt_ds_n;
            write_low_dir_ff    <= nxt_wld;
            as_oe_ff            <= !nxt_float; // R5
            ds_oe_ff            <= !nxt_float; // R5
            wld_oe_ff           <= !nxt_float; // R5
            p0_out_ff           <= nxt_p0o;
            p0_oe_ff            <= nxt_p0e;
            p1_out_ff           <= nxt_p1o;
            p1_oe_ff            <= nxt_p1e;
            p2_out_ff           <= p2_io_out;
            p2_oe_ff            <= nxt_p2e;
            p3_out_ff           <= nxt_p3o;
        end
    end

    assign hs_on[0] = hs_en[0] && !p0_lo_eff && !p0_hi_eff &&
                      (p0_dir[0] == p0_dir[1]); // R13
    assign hs_on[1] = hs_en[1] && !bus_share_en &&
                      (p1_mode == P1_MODE_IN || p1_mode == P1_MODE_OUT); // R17
    assign hs_on[2] = hs_en[2]; // R21
    assign hs_send  = {p2_dir[7], (p1_mode == P1_MODE_OUT), p0_dir[1]}; // R21
    assign hs_in    = {p3_in[P3I_P2HS], p3_in[P3I_P1HS], p3_in[P3I_P0HS]};
    assign hs_pins[0] = p0_in;
    assign hs_pins[1] = p1_in;
    assign hs_pins[2] = p2_in;

    for (genvar i = 0; i < 3; i++) begin : g_hs
        iop_hs #(
            .W           (8)
        ) u_hs (
            .clk         (clk),
            .rst         (rst),
            .enable      (hs_on[i]),
            .send        (hs_send[i]),
            .line_in     (hs_in[i]),
            .pins_in     (hs_pins[i]),
            .line_out_ff (hs_line[i]),
            .wr_stb      (hs_wr_stb[i]),
            .rd_ack      (hs_rd_ack[i]),
            .rd_data_ff  (hs_data[i]),
            .full_ff     (hs_full[i]),
            .busy_ff     (hs_busy[i])
        );
    end

    assign p0_rd_data = hs_data[0];
    assign p1_rd_data = hs_data[1];
    assign p2_rd_data = hs_data[2];

    property p_as_pulse;
        @(posedge clk) disable iff (rst || int_rst)
        ($fell(address_strobe_n_ff) && !int_rst && !internal_reset_ff)
            |=> address_strobe_n_ff [*3];
    endproperty
    a_as_pulse: assert property (p_as_pulse) // R3
        else $error("Address strobe pulse not once per cycle");

    property p_ds_once;
        @(posedge clk) disable iff (rst || internal_reset_ff || int_rst)
        $fell(data_strobe_n_ff) |-> ##[1:2] data_strobe_n_ff
            ##1 data_strobe_n_ff [*2];
    endproperty
    a_ds_once: assert property (p_ds_once) // R2
        else $error("Data strobe not a single pulse");

    property p_low_addr;
        @(posedge clk) disable iff (rst)
        (xfer_ff && state_ff == S_AS && !bus_floated_ff)
            |-> (p1_out_ff == addr_ff[7:0]) && (p1_oe_ff == 8'hff);
    endproperty
    a_low_addr: assert property (p_low_addr) // R4
        else $error("Low address byte missing on port 1");

    property p_float;
        @(posedge clk) disable iff (rst)
        bus_floated_ff |-> !as_oe_ff && !ds_oe_ff && !wld_oe_ff &&
            (p0_oe_ff == 8'h00) && (p1_oe_ff == 8'h00);
    endproperty
    a_float: assert property (p_float) // R5
        else $error("Bus driven while floated");

    property p_wld;
        @(posedge clk) disable iff (rst)
        !write_low_dir_ff |-> xfer_ff && we_ff && wld_oe_ff;
    endproperty
    a_wld: assert property (p_wld) // R6
        else $error("Write direction low outside a write");

    property p_rst_strobes;
        @(posedge clk) disable iff (rst)
        (internal_reset_ff && $past(internal_reset_ff) && !$past(rst))
            |-> !data_strobe_n_ff &&
                (address_strobe_n_ff != $past(address_strobe_n_ff));
    endproperty
    a_rst_strobes: assert property (p_rst_strobes) // R9
        else $error("Strobes wrong during reset cycle");

    property p_vector;
        @(posedge clk) disable iff (rst)
        $fell(internal_reset_ff) |-> exec_start_ff &&
            (exec_addr_ff == RESET_VECTOR) ##1 !exec_start_ff;
    endproperty
    a_vector: assert property (p_vector) // R10
        else $error("No restart at reset vector");

    property p_romless_init;
        @(posedge clk) disable iff (rst)
        ($fell(internal_reset_ff) && rom_off_ff && !p0_cfg_wr)
            |-> ext_timing_ff && p0_lo_eff && p0_hi_eff;
    endproperty
    a_romless_init: assert property (p_romless_init) // R15
        else $error("ROM-off reset did not set address and timing");

    property p_open_drain;
        @(posedge clk) disable iff (rst)
        $past(p2_open_drain) |-> (p2_oe_ff & p2_out_ff) == 8'h00;
    endproperty
    a_open_drain: assert property (p_open_drain) // R20
        else $error("Port 2 drives high in open-drain mode");

endmodule : iop_bus_ports

// ---- core/iop_hs.sv ----
`timescale 1ns/1ps
module iop_hs #(
    parameter int W = 8
) (
    // Clock and reset
    input  wire logic         clk,
    input  wire logic         rst,
    // Mode
    input  wire logic         enable,
    input  wire logic         send,
    // Handshake and data lines
    input  wire logic         line_in,
    input  wire logic [W-1:0] pins_in,
    output logic              line_out_ff,
    // Core side
    input  wire logic         wr_stb,
    input  wire logic         rd_ack,
    output logic [W-1:0]      rd_data_ff,
    output logic              full_ff,
    output logic              busy_ff
);

    // Receive: line_in is data available (low), line_out is ready
    // Send: line_in is ready, line_out is data available (low)
    logic stable_ff;
    logic latch;
    logic nxt_full;

    assign latch    = enable && !send && !line_in && line_out_ff && !full_ff;
    assign nxt_full = latch || (full_ff && !rd_ack && enable && !send);

    always_ff @(posedge clk) begin
        if (rst) begin
            full_ff    <= 1'b0;
            rd_data_ff <= '0;
        end else begin
            full_ff <= nxt_full; // R22
            if (latch || !enable) begin
                rd_data_ff <= pins_in;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst || !enable || !send) begin
            busy_ff   <= 1'b0;
            stable_ff <= 1'b0;
        end else if (wr_stb && !busy_ff) begin
            busy_ff   <= 1'b1;
            stable_ff <= 1'b0;
        end else if (busy_ff) begin
            stable_ff <= 1'b1;
            if (!line_out_ff && !line_in) begin
                busy_ff <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst || !enable) begin
            line_out_ff <= 1'b1;
        end else if (send) begin
            if (!line_out_ff) begin
                line_out_ff <= !line_in; // R22
            end else begin
                line_out_ff <= !(busy_ff && stable_ff && line_in); // R22
            end
        end else begin
            line_out_ff <= !nxt_full && line_in; // R22
        end
    end

    property p_ready_drop;
        @(posedge clk) disable iff (rst)
        (enable && !send && $past(enable) && !$past(send) && $fell(line_out_ff))
            |-> full_ff || !$past(line_in);
    endproperty
    a_ready_drop: assert property (p_ready_drop) // R22
        else $error("Ready dropped without data taken");

endmodule : iop_hs

// ---- core/iop_pkg.sv ----
package iop_pkg;

    // Reset sequencing, in input clock periods
    localparam int RST_FILTER_CYC = 4;
    localparam int RST_HOLD_CYC   = 18;

    // Program start after reset, and first external location in ROM mode
    localparam logic [15:0] RESET_VECTOR = 16'h000c;
    localparam logic [15:0] EXT_BASE     = 16'h2000;

    // Port 1 byte modes
    localparam logic [1:0] P1_MODE_IN  = 2'h0;
    localparam logic [1:0] P1_MODE_OUT = 2'h1;
    localparam logic [1:0] P1_MODE_BUS = 2'h2;

    // Port 3 input bits: index 0 is P30 ... 3 is P33
    localparam int P3I_P2HS   = 1;
    localparam int P3I_P0HS   = 2;
    localparam int P3I_P1HS   = 3;
    localparam int P3I_BUSACK = 3;

    // Port 3 output bits: index 0 is P34 ... 3 is P37
    localparam int P3O_P1HS   = 0;
    localparam int P3O_BUSREQ = 0;
    localparam int P3O_P0HS   = 1;
    localparam int P3O_P2HS   = 2;

    // Machine cycle phases
    typedef enum logic [2:0] {
        S_AS  = 3'h0,
        S_AH  = 3'h1,
        S_DS  = 3'h2,
        S_DW  = 3'h3,
        S_END = 3'h4
    } iop_bus_st_t;

endpackage : iop_pkg

// ---- core/iop_rst_filter.sv ----
`timescale 1ns/1ps
module iop_rst_filter
    import iop_pkg::*;
#(
    parameter int FILT_CYC = RST_FILTER_CYC,
    parameter int HOLD_CYC = RST_HOLD_CYC
) (
    // Clock and system reset
    input  wire logic clk,
    input  wire logic rst,
    // Pin side
    input  wire logic ext_reset_in_n,
    // Core side
    output logic      int_rst_ff
);

    localparam logic [3:0] FILT_LAST = 4'(FILT_CYC - 1);
    localparam logic [7:0] HOLD_LOAD = 8'(HOLD_CYC - 1);

    logic [3:0] low_cnt_ff;
    logic [7:0] hold_ff;
    logic       fire;

    assign fire = !ext_reset_in_n && (low_cnt_ff == FILT_LAST) && !int_rst_ff;

    always_ff @(posedge clk) begin
        if (rst || ext_reset_in_n) begin
            low_cnt_ff <= 4'h0;
        end else if (low_cnt_ff != FILT_LAST) begin
            low_cnt_ff <= low_cnt_ff + 4'h1; // R7
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            hold_ff <= HOLD_LOAD;
        end else if (fire) begin
            hold_ff <= HOLD_LOAD; // R8
        end else if (hold_ff != 8'h00) begin
            hold_ff <= hold_ff - 8'h01;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            int_rst_ff <= 1'b1;
        end else if (fire) begin
            int_rst_ff <= 1'b1; // R8
        end else if (hold_ff == 8'h00 && ext_reset_in_n) begin
            int_rst_ff <= 1'b0; // R8
        end
    end

    property p_short_pulse;
        @(posedge clk) disable iff (rst)
        (!int_rst_ff && ext_reset_in_n) ##1 (!ext_reset_in_n) [*3]
            ##1 ext_reset_in_n |=> !int_rst_ff;
    endproperty
    a_short_pulse: assert property (p_short_pulse) // R7
        else $error("Short reset pulse caused a reset");

    property p_fifth_clock;
        @(posedge clk) disable iff (rst)
        ext_reset_in_n ##1 (!ext_reset_in_n) [*4] |=> int_rst_ff;
    endproperty
    a_fifth_clock: assert property (p_fifth_clock) // R8
        else $error("Internal reset not latched on fifth clock");

    property p_hold_min;
        @(posedge clk) disable iff (rst)
        $rose(int_rst_ff) |-> int_rst_ff throughout (1'b1 ##17 1'b1);
    endproperty
    a_hold_min: assert property (p_hold_min) // R8
        else $error("Internal reset shorter than hold count");

endmodule : iop_rst_filter

// ---- tb/iop_bus_ports_tb.sv ----
`timescale 1ns/1ps
module iop_bus_ports_tb
    import iop_pkg::*;
;
    logic clk = 0, rst = 1, ext_reset_in_n = 1, rom_disable_n = 1;
    logic mem_req = 0, mem_we = 0, p0_addr_lo = 1, p0_addr_hi = 1;
    logic p0_cfg_wr = 0, ext_timing_cfg = 0, p2_open_drain = 0;
    logic bus_float_req = 0, bus_share_en = 0;
    logic [15:0] mem_addr = 16'h0000;
    logic [7:0] mem_wdata = 8'h00, p2_dir = 8'h00, p0_in = 8'h00;
    logic [7:0] p0_io_out = 8'h00, p1_io_out = 8'h00, p2_io_out = 8'h00;
    logic [7:0] p2_in = 8'h00, p1_in, as_addr, n_ds;
    logic [1:0] p0_dir = 2'h3, p1_mode = P1_MODE_BUS;
    logic [2:0] hs_en = 3'h0, hs_wr_stb = 3'h0, hs_rd_ack = 3'h0;
    logic [3:0] p3_core_out = 4'h0, p3_in = 4'h0;
    logic internal_reset_ff, rom_off_ff, exec_start_ff, mem_done_ff;
    logic mem_internal_ff, ext_timing_ff, bus_floated_ff, as_oe_ff;
    logic address_strobe_n_ff, data_strobe_n_ff, ds_oe_ff, wld_oe_ff;
    logic write_low_dir_ff, ds_prev = 1, wld_seen;
    logic [15:0] exec_addr_ff;
    logic [7:0] mem_rdata_ff, p0_rd_data, p1_rd_data, p2_rd_data;
    logic [7:0] p0_out_ff, p0_oe_ff, p1_out_ff, p1_oe_ff, p2_out_ff, p2_oe_ff;
    logic [2:0] hs_full, hs_busy;
    logic [3:0] p3_out_ff;
    int n_mismatch = 0, total_checks = 0, cyc = 0, n_as;

    iop_bus_ports iop_bus_ports_inst (.*);
    iop_ext_mem iop_ext_mem_inst (.clk(clk), .as_n(address_strobe_n_ff),
        .ds_n(data_strobe_n_ff), .wr_n(write_low_dir_ff),
        .ad_out(p1_out_ff), .ad_in(p1_in));

    initial forever #25 clk = ~clk;
    always @(posedge clk) begin
        if (ds_prev && !data_strobe_n_ff) n_ds++;
        ds_prev = data_strobe_n_ff;
        if (!write_low_dir_ff) wld_seen = 1;
        if (!address_strobe_n_ff && n_ds == 0) as_addr = p1_out_ff;
        if (++cyc == 20000) begin
            n_mismatch++;
            give_verdict();
        end
    end

    task automatic check(input string what, input logic [15:0] seen, exp);
        total_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic wait_start();
        for (int i = 0; i < 100 && exec_start_ff !== 1'b1; i++) @(negedge clk);
        check("start", exec_start_ff, 1);
    endtask : wait_start

    task automatic t_hs();
        p2_in = 8'h5a;
        hs_en = 3'h4;
        repeat (2) @(negedge clk);
        check("hs_take", {hs_full[2], p3_out_ff[2], p2_rd_data}, 16'h25a);
        p3_in[1] = 1;
        hs_rd_ack[2] = 1;
        @(negedge clk);
        hs_rd_ack[2] = 0;
        @(negedge clk);
        check("hs_free", {hs_full[2], p3_out_ff[2]}, 2'h1);
    endtask : t_hs

    task automatic t_romless();
        rom_disable_n = 0;
        p0_addr_lo = 0;
        p0_addr_hi = 0;
        ext_reset_in_n = 0;
        repeat (6) @(negedge clk);
        ext_reset_in_n = 1;
        wait_start();
        check("rom_off", {rom_off_ff, ext_timing_ff}, 2'h3);
        mem_op(0, 1, 16'h0100, 8'h00);
        check("p0_addr", p0_out_ff, 8'h01);
        p0_cfg_wr = 1;
        @(negedge clk);
        p0_cfg_wr = 0;
        @(negedge clk);
        check("reconfig", {ext_timing_ff, p0_out_ff}, 9'h000);
    endtask : t_romless

    task automatic t_reset();
        @(negedge clk);
        check("ds_in_reset", data_strobe_n_ff, 0);
        wait_start();
        check("vector", exec_addr_ff, 16'h000c);
        n_as = 0;
        repeat (40) begin
            @(negedge clk);
            n_as += !address_strobe_n_ff;
        end
        check("as_rate", n_as, 10);
    endtask : t_reset

    task automatic t_filter();
        ext_reset_in_n = 0;
        repeat (3) @(negedge clk);
        ext_reset_in_n = 1;
        repeat (5) @(negedge clk);
        check("short_pulse", internal_reset_ff, 0);
        ext_reset_in_n = 0;
        repeat (6) @(negedge clk);
        check("long_pulse", internal_reset_ff, 1);
        repeat (20) @(negedge clk);
        check("pin_held", internal_reset_ff, 1);
        ext_reset_in_n = 1;
        wait_start();
        check("restart", exec_addr_ff, 16'h000c);
    endtask : t_filter

    task automatic mem_op(input logic we, ext, input logic [15:0] a,
                          input logic [7:0] d);
        mem_we = we;
        mem_addr = a;
        mem_wdata = d;
        mem_req = 1;
        n_ds = 0;
        wld_seen = 0;
        for (int i = 0; i < 50 && mem_done_ff !== 1'b1; i++) @(negedge clk);
        mem_req = 0;
        check("ds_count", n_ds, ext);
        check("wr_dir", wld_seen, we);
        check("internal", mem_internal_ff, !ext);
        if (ext) check("addr_lo", as_addr, a[7:0]);
        @(negedge clk);
    endtask : mem_op

    task automatic t_float();
        bus_share_en = 1;
        bus_float_req = 1;
        repeat (12) @(negedge clk);
        check("req_no_ack", {p3_out_ff[0], bus_floated_ff}, 2'h2);
        p3_in[3] = 1;
        for (int i = 0; i < 20 && bus_floated_ff !== 1'b1; i++) @(negedge clk);
        check("floated", {as_oe_ff, ds_oe_ff, wld_oe_ff, p1_oe_ff}, 0);
        bus_float_req = 0;
        repeat (12) @(negedge clk);
        check("resumed", as_oe_ff, 1);
    endtask : t_float

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : give_verdict

    initial begin
        repeat (20) @(negedge clk);
        rst = 0;
        t_reset();
        t_filter();
        mem_op(1, 1, 16'h2345, 8'ha7);
        mem_op(0, 1, 16'h2345, 8'h00);
        check("rdata", mem_rdata_ff, 8'ha7);
        mem_op(0, 0, 16'h0100, 8'h00);
        t_float();
        t_hs();
        t_romless();
        give_verdict();
    end
endmodule : iop_bus_ports_tb

// ---- tb/iop_ext_mem.sv ----
`timescale 1ns/1ps
module iop_ext_mem (
    // Bus side
    input  wire logic       clk,
    input  wire logic       as_n,
    input  wire logic       ds_n,
    input  wire logic       wr_n,
    input  wire logic [7:0] ad_out,
    output logic      [7:0] ad_in
);
    logic [7:0] mem [256];
    logic [7:0] addr_ff = 8'h00;
    logic [7:0] last_ff = 8'h00;
    always_ff @(posedge clk) begin
        if (!as_n) addr_ff <= ad_out;
        if (!ds_n && !wr_n) mem[addr_ff] <= ad_out;
        if (!ds_n && wr_n) last_ff <= mem[addr_ff];
    end
    // Released bus shows the inverse of the last byte
    assign ad_in = (!ds_n && wr_n) ? mem[addr_ff] : ~last_ff;
endmodule : iop_ext_mem
